// ---- src/sfr_bank_map.svh ----
`ifndef SFR_BANK_MAP_SVH
`define SFR_BANK_MAP_SVH

// Register offsets in the direct-addressed upper half
`define PORT0_LATCH_ADDR        8'h80
`define STACK_POINTER_ADDR      8'h81
`define DATA_POINTER0_LOW_ADDR  8'h82
`define DATA_POINTER0_HIGH_ADDR 8'h83
`define DATA_POINTER1_LOW_ADDR  8'h84
`define DATA_POINTER1_HIGH_ADDR 8'h85
`define POWER_UART_SPEED_ADDR   8'h87
`define TIMER_RUN_CTRL_ADDR     8'h88
`define TIMER_MODE_CTRL_ADDR    8'h89
`define TIMER0_COUNT_LO_ADDR    8'h8a
`define TIMER1_COUNT_LO_ADDR    8'h8b
`define TIMER0_COUNT_HI_ADDR    8'h8c
`define TIMER1_COUNT_HI_ADDR    8'h8d
`define MEMORY_STRETCH_ADDR     8'h8e
`define PORT1_LATCH_ADDR        8'h90
`define POINTER_SELECT_ADDR     8'h92
`define SERIAL0_CTRL_ADDR       8'h98
`define SERIAL0_BUFFER_ADDR     8'h99
`define IRQ_ENABLE_TWO_ADDR     8'h9a
`define SERIAL1_CTRL_ADDR       8'h9b
`define SERIAL1_BUFFER_ADDR     8'h9c
`define SERIAL1_RELOAD_LOW_ADDR 8'h9d
`define PORT2_LATCH_ADDR        8'ha0
`define IRQ_ENABLE_ZERO_ADDR    8'ha8
`define IRQ_PRIORITY_ZERO_ADDR  8'ha9
`define SERIAL0_RELOAD_LOW_ADDR 8'haa
`define PORT3_LATCH_ADDR        8'hb0
`define IRQ_ENABLE_ONE_ADDR     8'hb8
`define IRQ_PRIORITY_ONE_ADDR   8'hb9
`define SERIAL0_RELOAD_HI_ADDR  8'hba
`define SERIAL1_RELOAD_HI_ADDR  8'hbb
`define PAGED_MOVX_HIGH_ADDR    8'hbf
`define IRQ_REQUEST_FLAGS_ADDR  8'hc0
`define EXT_IRQ_POLARITY_ADDR   8'hc8
`define PROGRAM_STATUS_ADDR     8'hd0
`define BAUD_RATE_CTRL_ADDR     8'hd8
`define ACCUMULATOR_ADDR        8'he0
`define MULTIPLY_DIVIDE_ADDR    8'hf0

// Reset values that differ from zero, then the zero default
`define PORT_LATCH_RESET        8'hff
`define STACK_POINTER_RESET     8'h07
`define MEMORY_STRETCH_RESET    8'h01
`define SERIAL0_RELOAD_LO_RESET 8'hd9
`define SERIAL_RELOAD_HI_RESET  8'h03
`define DEFAULT_RESET           8'h00

// Field positions, masks and the unmapped read value
`define BAUD_RATE_CTRL_MASK     8'h80
`define BAUD_DOUBLE_BIT         7
`define POINTER_SELECT_BIT      0
`define PARITY_BIT              0
`define BIT_ADDRESSABLE_MASK    3'h0
`define UNMAPPED_READ_VALUE     8'h00

`endif

// ---- src/sfr_bank_pkg.sv ----
package sfr_bank_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [6:0] sfr_index_t;
  typedef logic [15:0] sfr_word_t;
endpackage

// ---- src/mcu_core_sfr_bank.sv ----
// Notes on behaviour
// - Reset loads listed values: ports 0xff, stack pointer 0x07, stretch 0x01, reloads below, else 0x00.
// - Serial port 0 reload resets to 0xd9 at 0xaa and 0x03 at 0xba.
// - Serial port 1 reload resets to 0x00 at 0x9d and 0x03 at 0xbb.
// - The register at 0xbf gives the high byte of paged data moves.
// - The baud rate register at 0xd8 keeps only bit 7, reset 0x00.
// - The register at 0xc8 holds ext irq two/three polarity, reset 0x00.
// - The accumulator at 0xe0 is core operand and plain read/write byte.
// - The register at 0xf0 takes mul/div results, else scratch data.
// - Pointer select at 0x92 resets to 0x00; pointers fill 0x82 to 0x85.
// - Power and serial speed control at 0x87 resets to 0x00.
// - Enables at 0xa8, 0xb8, 0x9a and priorities at 0xa9, 0xb9 reset to 0.
// - Request flags at 0xc0 hold pending extended irqs, reset 0x00.
// - Select bit 0 picks pointer one or two, leaving both pointers intact.
// - The stack pointer steps up before a push or call; first push at 0x08.
// - Unimplemented addresses read 0x00 without a hit and ignore writes.
// - Registers at multiples of eight from 0x80 also take bit access.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_map.svh"

module mcu_core_sfr_bank
  import sfr_bank_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_wdata,
  input wire logic i_acc_load,
  input wire logic [7:0] i_acc_value,
  input wire logic i_muldiv_load,
  input wire logic [7:0] i_muldiv_value,
  input wire logic i_sp_inc,
  input wire logic i_sp_dec,
  input wire logic i_psw_load,
  input wire logic [7:0] i_psw_value,
  input wire logic i_first_data_pointer_load,
  input wire logic [15:0] i_first_data_pointer_value,
  input wire logic i_first_data_pointer_inc,
  input wire logic [7:0] i_irq_req_set,
  input wire logic [7:0] i_ri_value,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_rd_hit,
  output logic o_bit_rdata,
  output logic [7:0] o_acc,
  output logic [7:0] o_muldiv,
  output logic [7:0] o_sp,
  output logic [7:0] o_psw,
  output logic [15:0] o_active_first_data_pointer,
  output logic [15:0] o_paged_addr,
  output logic [7:0] o_port0,
  output logic [7:0] o_port1,
  output logic [7:0] o_port2,
  output logic [7:0] o_port3,
  output logic [7:0] o_power_ctrl,
  output logic [7:0] o_timer_run,
  output logic [7:0] o_timer_mode,
  output logic [7:0] o_stretch,
  output logic [15:0] o_serial0_reload,
  output logic [15:0] o_serial1_reload,
  output logic [7:0] o_irq_enable0,
  output logic [7:0] o_irq_enable1,
  output logic [7:0] o_irq_enable2,
  output logic [7:0] o_irq_priority0,
  output logic [7:0] o_irq_priority1,
  output logic [7:0] o_irq_request,
  output logic [7:0] o_ext_irq_polarity,
  output logic o_baud_double
);

  // --------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------

  // Only the upper half is decoded; lower-half addresses never hit
  function automatic logic is_implemented(input logic [7:0] addr);
    case (addr)
      `PORT0_LATCH_ADDR,
      `STACK_POINTER_ADDR,
      `DATA_POINTER0_LOW_ADDR,
      `DATA_POINTER0_HIGH_ADDR,
      `DATA_POINTER1_LOW_ADDR,
      `DATA_POINTER1_HIGH_ADDR,
      `POWER_UART_SPEED_ADDR,
      `TIMER_RUN_CTRL_ADDR,
      `TIMER_MODE_CTRL_ADDR,
      `TIMER0_COUNT_LO_ADDR,
      `TIMER1_COUNT_LO_ADDR,
      `TIMER0_COUNT_HI_ADDR,
      `TIMER1_COUNT_HI_ADDR,
      `MEMORY_STRETCH_ADDR,
      `PORT1_LATCH_ADDR,
      `POINTER_SELECT_ADDR,
      `SERIAL0_CTRL_ADDR,
      `SERIAL0_BUFFER_ADDR,
      `IRQ_ENABLE_TWO_ADDR,
      `SERIAL1_CTRL_ADDR,
      `SERIAL1_BUFFER_ADDR,
      `SERIAL1_RELOAD_LOW_ADDR,
      `PORT2_LATCH_ADDR,
      `IRQ_ENABLE_ZERO_ADDR,
      `IRQ_PRIORITY_ZERO_ADDR,
      `SERIAL0_RELOAD_LOW_ADDR,
      `PORT3_LATCH_ADDR,
      `IRQ_ENABLE_ONE_ADDR,
      `IRQ_PRIORITY_ONE_ADDR,
      `SERIAL0_RELOAD_HI_ADDR,
      `SERIAL1_RELOAD_HI_ADDR,
      `PAGED_MOVX_HIGH_ADDR,
      `IRQ_REQUEST_FLAGS_ADDR,
      `EXT_IRQ_POLARITY_ADDR,
      `PROGRAM_STATUS_ADDR,
      `BAUD_RATE_CTRL_ADDR,
      `ACCUMULATOR_ADDR,
      `MULTIPLY_DIVIDE_ADDR:
        is_implemented = addr[7];
      default: is_implemented = 1'b0;
    endcase
  endfunction

  function automatic sfr_byte_t reset_value(input logic [7:0] addr);
    case (addr)
      `PORT0_LATCH_ADDR, `PORT1_LATCH_ADDR,
      `PORT2_LATCH_ADDR, `PORT3_LATCH_ADDR:
        reset_value = `PORT_LATCH_RESET;
      `STACK_POINTER_ADDR: reset_value = `STACK_POINTER_RESET;
      `MEMORY_STRETCH_ADDR: reset_value = `MEMORY_STRETCH_RESET;
      `SERIAL0_RELOAD_LOW_ADDR: reset_value = `SERIAL0_RELOAD_LO_RESET;
      `SERIAL0_RELOAD_HI_ADDR: reset_value = `SERIAL_RELOAD_HI_RESET;
      `SERIAL1_RELOAD_HI_ADDR: reset_value = `SERIAL_RELOAD_HI_RESET;
      default: reset_value = `DEFAULT_RESET;
    endcase
  endfunction

  // Bits that hold no storage read back as zero
  function automatic sfr_byte_t write_mask(input logic [7:0] addr);
    if (addr == `BAUD_RATE_CTRL_ADDR) begin
      write_mask = `BAUD_RATE_CTRL_MASK;
    end else begin
      write_mask = 8'hff;
    end
  endfunction

  function automatic sfr_index_t index_of(input logic [7:0] addr);
    index_of = addr[6:0];
  endfunction

  function automatic logic even_parity(input sfr_byte_t value);
    even_parity = ^value;
  endfunction

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------

  // Indexed by the low seven address bits; entries at unimplemented
  // addresses are never written and are trimmed by synthesis.
  sfr_byte_t regs_r [0:127];
  sfr_byte_t regs_nxt [0:127];

  logic [7:0] bit_reg_addr;
  logic bit_wr_hit;
  logic byte_wr_hit;
  logic sel_second;
  logic [7:0] ptr_lo_addr;
  logic [7:0] ptr_hi_addr;
  sfr_word_t ptr_cur;
  sfr_word_t ptr_new;
  sfr_byte_t sp_base;
  sfr_byte_t psw_base;
  sfr_byte_t bit_mask;

  // Bit address: upper five bits name the register, low three the bit
  assign bit_reg_addr = {i_bit_addr[7:3], `BIT_ADDRESSABLE_MASK};
  assign bit_wr_hit = i_bit_wr && i_bit_addr[7] &&
                      is_implemented(bit_reg_addr);
  assign byte_wr_hit = i_sfr_wr && is_implemented(i_sfr_addr);

  // --------------------------------------------------------------
  // Next-state computation
  // --------------------------------------------------------------

  always_comb begin
    for (int i = 0; i < 128; i++) begin
      regs_nxt[i] = regs_r[i];
    end

    // Core side effects come first; a firmware write in the same
    // cycle is the later event of the instruction and overrides them.
    if (i_acc_load) begin
      regs_nxt[index_of(`ACCUMULATOR_ADDR)] = i_acc_value;
    end
    if (i_muldiv_load) begin
      regs_nxt[index_of(`MULTIPLY_DIVIDE_ADDR)] = i_muldiv_value;
    end
    if (i_psw_load) begin
      regs_nxt[index_of(`PROGRAM_STATUS_ADDR)] = i_psw_value;
    end

    // Pre-increment before a push or call
    sp_base = regs_r[index_of(`STACK_POINTER_ADDR)];
    if (i_sp_inc && !i_sp_dec) begin
      regs_nxt[index_of(`STACK_POINTER_ADDR)] = sp_base + 8'h01;
    end else if (i_sp_dec && !i_sp_inc) begin
      regs_nxt[index_of(`STACK_POINTER_ADDR)] = sp_base - 8'h01;
    end

    // Pointer updates land only in the selected pair
    if (i_first_data_pointer_load || i_first_data_pointer_inc) begin
      regs_nxt[index_of(ptr_lo_addr)] = ptr_new[7:0];
      regs_nxt[index_of(ptr_hi_addr)] = ptr_new[15:8];
    end

    // Hardware sets pending flags; a set beats a software clear
    regs_nxt[index_of(`IRQ_REQUEST_FLAGS_ADDR)] =
      regs_r[index_of(`IRQ_REQUEST_FLAGS_ADDR)] | i_irq_req_set;

    if (byte_wr_hit) begin
      regs_nxt[index_of(i_sfr_addr)] =
        i_sfr_wdata & write_mask(i_sfr_addr);
      if (i_sfr_addr == `IRQ_REQUEST_FLAGS_ADDR) begin
        regs_nxt[index_of(i_sfr_addr)] = i_sfr_wdata | i_irq_req_set;
      end
    end

    // Bit writes honour the same unstored bits as byte writes
    bit_mask = write_mask(bit_reg_addr);
    if (bit_wr_hit) begin
      regs_nxt[index_of(bit_reg_addr)][i_bit_addr[2:0]] =
        i_bit_wdata & bit_mask[i_bit_addr[2:0]];
      if (bit_reg_addr == `IRQ_REQUEST_FLAGS_ADDR) begin
        regs_nxt[index_of(bit_reg_addr)] =
          regs_nxt[index_of(bit_reg_addr)] | i_irq_req_set;
      end
    end

    // Parity always tracks the accumulator being stored
    psw_base = regs_nxt[index_of(`PROGRAM_STATUS_ADDR)];
    psw_base[`PARITY_BIT] =
      even_parity(regs_nxt[index_of(`ACCUMULATOR_ADDR)]);
    regs_nxt[index_of(`PROGRAM_STATUS_ADDR)] = psw_base;
  end

  // Active pointer selection from the current select bit
  always_comb begin
    sel_second = regs_r[index_of(`POINTER_SELECT_ADDR)]
                 [`POINTER_SELECT_BIT];
    if (sel_second) begin
      ptr_lo_addr = `DATA_POINTER1_LOW_ADDR;
      ptr_hi_addr = `DATA_POINTER1_HIGH_ADDR;
    end else begin
      ptr_lo_addr = `DATA_POINTER0_LOW_ADDR;
      ptr_hi_addr = `DATA_POINTER0_HIGH_ADDR;
    end
    ptr_cur = {regs_r[index_of(ptr_hi_addr)],
               regs_r[index_of(ptr_lo_addr)]};
    if (i_first_data_pointer_load) begin
      ptr_new = i_first_data_pointer_value;
    end else begin
      ptr_new = ptr_cur + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------

  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < 128; i++) begin
      if (i_reset) begin
        regs_r[i] <= reset_value({1'b1, 7'(i)});
      end else begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------

  // Unmapped reads return a fixed filler; software must not rely on it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_sfr_rdata <= `UNMAPPED_READ_VALUE;
      o_sfr_rd_hit <= 1'b0;
    end else if (i_sfr_rd) begin
      if (is_implemented(i_sfr_addr)) begin
        o_sfr_rdata <= regs_r[index_of(i_sfr_addr)];
        o_sfr_rd_hit <= 1'b1;
      end else begin
        o_sfr_rdata <= `UNMAPPED_READ_VALUE;
        o_sfr_rd_hit <= 1'b0;
      end
    end else begin
      o_sfr_rd_hit <= 1'b0;
    end
  end

  // Bit reads sample every cycle; the bit number needs no strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_bit_rdata <= 1'b0;
    end else if (i_bit_addr[7] && is_implemented(bit_reg_addr)) begin
      o_bit_rdata <= regs_r[index_of(bit_reg_addr)][i_bit_addr[2:0]];
    end else begin
      o_bit_rdata <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Derived core outputs
  // --------------------------------------------------------------

  // Registered from the next values so the core sees a stable pointer
  // in the cycle after any select or pointer change.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_active_first_data_pointer <= 16'h0000;
    end else if (regs_nxt[index_of(`POINTER_SELECT_ADDR)]
                 [`POINTER_SELECT_BIT]) begin
      o_active_first_data_pointer <= {regs_nxt[index_of(`DATA_POINTER1_HIGH_ADDR)],
                        regs_nxt[index_of(`DATA_POINTER1_LOW_ADDR)]};
    end else begin
      o_active_first_data_pointer <= {regs_nxt[index_of(`DATA_POINTER0_HIGH_ADDR)],
                        regs_nxt[index_of(`DATA_POINTER0_LOW_ADDR)]};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_paged_addr <= 16'h0000;
    end else begin
      o_paged_addr <= {regs_nxt[index_of(`PAGED_MOVX_HIGH_ADDR)],
                       i_ri_value};
    end
  end

  // --------------------------------------------------------------
  // Register contents to the core and peripherals
  // --------------------------------------------------------------

  assign o_acc = regs_r[index_of(`ACCUMULATOR_ADDR)];
  assign o_muldiv = regs_r[index_of(`MULTIPLY_DIVIDE_ADDR)];
  assign o_sp = regs_r[index_of(`STACK_POINTER_ADDR)];
  assign o_psw = regs_r[index_of(`PROGRAM_STATUS_ADDR)];
  assign o_port0 = regs_r[index_of(`PORT0_LATCH_ADDR)];
  assign o_port1 = regs_r[index_of(`PORT1_LATCH_ADDR)];
  assign o_port2 = regs_r[index_of(`PORT2_LATCH_ADDR)];
  assign o_port3 = regs_r[index_of(`PORT3_LATCH_ADDR)];
  assign o_power_ctrl = regs_r[index_of(`POWER_UART_SPEED_ADDR)];
  assign o_timer_run = regs_r[index_of(`TIMER_RUN_CTRL_ADDR)];
  assign o_timer_mode = regs_r[index_of(`TIMER_MODE_CTRL_ADDR)];
  assign o_stretch = regs_r[index_of(`MEMORY_STRETCH_ADDR)];
  assign o_serial0_reload = {regs_r[index_of(`SERIAL0_RELOAD_HI_ADDR)],
                             regs_r[index_of(`SERIAL0_RELOAD_LOW_ADDR)]};
  assign o_serial1_reload = {regs_r[index_of(`SERIAL1_RELOAD_HI_ADDR)],
                             regs_r[index_of(`SERIAL1_RELOAD_LOW_ADDR)]};
  assign o_irq_enable0 = regs_r[index_of(`IRQ_ENABLE_ZERO_ADDR)];
  assign o_irq_enable1 = regs_r[index_of(`IRQ_ENABLE_ONE_ADDR)];
  assign o_irq_enable2 = regs_r[index_of(`IRQ_ENABLE_TWO_ADDR)];
  assign o_irq_priority0 = regs_r[index_of(`IRQ_PRIORITY_ZERO_ADDR)];
  assign o_irq_priority1 = regs_r[index_of(`IRQ_PRIORITY_ONE_ADDR)];
  assign o_irq_request = regs_r[index_of(`IRQ_REQUEST_FLAGS_ADDR)];
  assign o_ext_irq_polarity = regs_r[index_of(`EXT_IRQ_POLARITY_ADDR)];
  assign o_baud_double = regs_r[index_of(`BAUD_RATE_CTRL_ADDR)]
                         [`BAUD_DOUBLE_BIT];

endmodule
`default_nettype wire

// ---- testbench/mcu_core_sfr_bank_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_checker
  import sfr_bank_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_sp_inc,
  input wire logic i_sp_dec,
  input wire logic [7:0] i_ri_value,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_rd_hit,
  input wire logic [7:0] o_sp,
  input wire logic [15:0] o_paged_addr,
  input wire logic [7:0] o_port0,
  input wire logic o_baud_double
);
  // ----------------
  // Port relations
  // ----------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Firmware byte writes win over the stack hooks, so leave them out
  wire logic sp_wr = i_sfr_wr && i_sfr_addr == 8'h81;

  AST_RESET_VALUES: assert property (disable iff (1'h0)
    i_reset |=> o_sp == 8'h07 && o_port0 == 8'hff && !o_sfr_rd_hit)
    else $error("reset values wrong");
  AST_SP_INC: assert property (
    i_sp_inc && !i_sp_dec && !sp_wr |=> o_sp == $past(o_sp) + 8'h01)
    else $error("stack pointer did not step up");
  AST_SP_BOTH: assert property (i_sp_inc && i_sp_dec && !sp_wr
    |=> $stable(o_sp)) else $error("stack pointer moved on both");
  AST_UNMAPPED: assert property (i_sfr_rd && !i_sfr_addr[7]
    |=> !o_sfr_rd_hit && o_sfr_rdata == 8'h00)
    else $error("lower half read hit");
  AST_HIT_ONLY_READ: assert property (!i_sfr_rd |=> !o_sfr_rd_hit)
    else $error("hit without read");
  AST_ACC_HIT: assert property (i_sfr_rd && i_sfr_addr == 8'he0
    |=> o_sfr_rd_hit) else $error("accumulator read missed");
  AST_BAUD_MASK: assert property (i_sfr_rd && i_sfr_addr == 8'hd8
    |=> o_sfr_rdata == {$past(o_baud_double), 7'h00})
    else $error("baud register read wrong");
  AST_PAGED: assert property (i_sfr_wr && i_sfr_addr == 8'hbf
    |=> o_paged_addr == {$past(i_sfr_wdata), $past(i_ri_value)})
    else $error("paged address wrong");
  AST_PORT_WRITE: assert property (i_sfr_wr && i_sfr_addr == 8'h80 &&
    !(i_bit_wr && i_bit_addr[7:3] == 5'h10)
    |=> o_port0 == $past(i_sfr_wdata)) else $error("port write lost");

  COV_SP_INC: cover property (i_sp_inc && !i_sp_dec);
  COV_UNMAPPED: cover property (i_sfr_rd && !i_sfr_addr[7]);
  COV_PAGED: cover property (i_sfr_wr && i_sfr_addr == 8'hbf);
endmodule

bind mcu_core_sfr_bank sfr_bank_checker chk (
  .i_mclk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
  .i_bit_addr, .i_bit_wr, .i_sp_inc, .i_sp_dec, .i_ri_value, .o_sfr_rdata,
  .o_sfr_rd_hit, .o_sp, .o_paged_addr, .o_port0, .o_baud_double
);
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("FAIL %0t got %h exp %h", $time, g, e); end end

module tb_top
  import sfr_bank_pkg::*;
;
  logic i_mclk = 1'h0, i_reset = 1'h1;
  logic i_sfr_wr = 1'h0, i_sfr_rd = 1'h0, i_bit_wr = 1'h0, i_bit_wdata = 1'h0;
  logic i_acc_load = 1'h0, i_muldiv_load = 1'h0, i_psw_load = 1'h0;
  logic i_sp_inc = 1'h0, i_sp_dec = 1'h0, i_first_data_pointer_load = 1'h0;
  logic i_first_data_pointer_inc = 1'h0;
  sfr_byte_t i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_bit_addr = 8'h00;
  sfr_byte_t i_acc_value = 8'h00, i_muldiv_value = 8'h00;
  sfr_byte_t i_psw_value = 8'h00, i_irq_req_set = 8'h00, i_ri_value = 8'h00;
  sfr_word_t i_first_data_pointer_value = 16'h0000;
  sfr_byte_t o_sfr_rdata, o_acc, o_muldiv, o_sp, o_psw, o_port0, o_port1;
  sfr_byte_t o_port2, o_port3, o_power_ctrl, o_timer_run, o_timer_mode;
  sfr_byte_t o_stretch, o_irq_enable0, o_irq_enable1, o_irq_enable2;
  sfr_byte_t o_irq_priority0, o_irq_priority1, o_irq_request;
  sfr_byte_t o_ext_irq_polarity;
  sfr_word_t o_active_first_data_pointer, o_paged_addr, o_serial0_reload, o_serial1_reload;
  logic o_sfr_rd_hit, o_bit_rdata, o_baud_double;
  int error_cnt = 0;
  int samples_checked = 0;
  sfr_byte_t d;
  logic h;
  sfr_byte_t map_q[$] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87,
    8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h92, 8'h98,
    8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'ha0, 8'ha8, 8'ha9, 8'haa, 8'hb0,
    8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbf, 8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0,
    8'hf0};

  mcu_core_sfr_bank dut (
    .i_mclk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
    .i_bit_addr, .i_bit_wr, .i_bit_wdata, .i_acc_load, .i_acc_value,
    .i_muldiv_load, .i_muldiv_value, .i_sp_inc, .i_sp_dec, .i_psw_load,
    .i_psw_value, .i_first_data_pointer_load, .i_first_data_pointer_value, .i_first_data_pointer_inc, .i_irq_req_set,
    .i_ri_value, .o_sfr_rdata, .o_sfr_rd_hit, .o_bit_rdata, .o_acc,
    .o_muldiv, .o_sp, .o_psw, .o_active_first_data_pointer, .o_paged_addr, .o_port0,
    .o_port1, .o_port2, .o_port3, .o_power_ctrl, .o_timer_run,
    .o_timer_mode, .o_stretch, .o_serial0_reload, .o_serial1_reload,
    .o_irq_enable0, .o_irq_enable1, .o_irq_enable2, .o_irq_priority0,
    .o_irq_priority1, .o_irq_request, .o_ext_irq_polarity, .o_baud_double
  );

  always #5 i_mclk = ~i_mclk;

  // -------------------------------
  // Access tasks, driven off-edge
  // -------------------------------
  function automatic sfr_byte_t rv(input sfr_byte_t a);
    case (a)
      8'h80, 8'h90, 8'ha0, 8'hb0: rv = 8'hff;
      8'h81: rv = 8'h07;
      8'h8e: rv = 8'h01;
      8'haa: rv = 8'hd9;
      8'hba, 8'hbb: rv = 8'h03;
      default: rv = 8'h00;
    endcase
  endfunction

  task automatic wr(input sfr_byte_t a, input sfr_byte_t v);
    @(negedge i_mclk);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    i_sfr_wr = 1'h1;
    @(negedge i_mclk);
    i_sfr_wr = 1'h0;
  endtask

  // Hit stands a single cycle, so it is captured at the very next negedge
  task automatic rd(input sfr_byte_t a);
    @(negedge i_mclk);
    i_sfr_addr = a;
    i_sfr_rd = 1'h1;
    @(negedge i_mclk);
    i_sfr_rd = 1'h0;
    d = o_sfr_rdata;
    h = o_sfr_rd_hit;
  endtask

  task automatic bw(input sfr_byte_t a, input logic v);
    @(negedge i_mclk);
    i_bit_addr = a;
    i_bit_wdata = v;
    i_bit_wr = 1'h1;
    @(negedge i_mclk);
    i_bit_wr = 1'h0;
  endtask

  task automatic pulse(ref logic s);
    @(negedge i_mclk);
    s = 1'h1;
    @(negedge i_mclk);
    s = 1'h0;
  endtask

  task conclude;
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (5) @(negedge i_mclk);
    i_reset = 1'h0;
    foreach (map_q[i]) begin
      rd(map_q[i]);
      `CHK(d, rv(map_q[i]))
      `CHK(h, 1'h1)
    end
    $display("test reset_values done");
    // Flags and baud byte have masked bits, they are checked apart
    foreach (map_q[i]) begin
      if (map_q[i] != 8'hd0 && map_q[i] != 8'hd8) begin
        wr(map_q[i], 8'ha5);
        rd(map_q[i]);
        `CHK(d, 8'ha5)
      end
    end
    `CHK({o_port1, o_port2, o_port3, o_power_ctrl}, 32'ha5a5a5a5)
    `CHK({o_timer_run, o_timer_mode, o_stretch}, 24'ha5a5a5)
    `CHK({o_muldiv, o_ext_irq_polarity}, 16'ha5a5)
    `CHK({o_irq_enable0, o_irq_enable1, o_irq_enable2}, 24'ha5a5a5)
    `CHK({o_irq_priority0, o_irq_priority1}, 16'ha5a5)
    wr(8'hd8, 8'hff);
    rd(8'hd8);
    `CHK(d, 8'h80)
    `CHK(o_baud_double, 1'h1)
    wr(8'h86, 8'h11);
    rd(8'h86);
    `CHK(h, 1'h0)
    rd(8'h40);
    `CHK(h, 1'h0)
    $display("test readback done");
    @(negedge i_mclk);
    i_reset = 1'h1;
    repeat (2) @(negedge i_mclk);
    i_reset = 1'h0;
    `CHK(o_sp, 8'h07)
    `CHK(o_serial0_reload, 16'h03d9)
    `CHK(o_serial1_reload, 16'h0300)
    `CHK({o_port0, o_port1, o_port2, o_port3}, 32'hffffffff)
    `CHK({o_stretch, o_power_ctrl, o_timer_run}, 24'h010000)
    `CHK({o_timer_mode, o_acc, o_muldiv, o_psw}, 32'h00000000)
    `CHK({o_irq_enable0, o_irq_enable1, o_irq_enable2}, 24'h000000)
    `CHK({o_irq_priority0, o_irq_priority1}, 16'h0000)
    `CHK({o_irq_request, o_ext_irq_polarity}, 16'h0000)
    `CHK({o_active_first_data_pointer, o_paged_addr}, 32'h00000000)
    pulse(i_sp_inc);
    `CHK(o_sp, 8'h08)
    @(negedge i_mclk);
    i_sp_inc = 1'h1;
    i_sp_dec = 1'h1;
    @(negedge i_mclk);
    i_sp_inc = 1'h0;
    i_sp_dec = 1'h0;
    `CHK(o_sp, 8'h08)
    pulse(i_sp_dec);
    `CHK(o_sp, 8'h07)
    $display("test stack done");
    i_first_data_pointer_value = 16'h1234;
    pulse(i_first_data_pointer_load);
    `CHK(o_active_first_data_pointer, 16'h1234)
    wr(8'h92, 8'h01);
    `CHK(o_active_first_data_pointer, 16'h0000)
    i_first_data_pointer_value = 16'hbeef;
    pulse(i_first_data_pointer_load);
    wr(8'h92, 8'h00);
    `CHK(o_active_first_data_pointer, 16'h1234)
    pulse(i_first_data_pointer_inc);
    `CHK(o_active_first_data_pointer, 16'h1235)
    rd(8'h85);
    `CHK(d, 8'hbe)
    i_ri_value = 8'h77;
    wr(8'hbf, 8'h3c);
    `CHK(o_paged_addr, 16'h3c77)
    $display("test pointers done");
    bw(8'he3, 1'h1);
    `CHK(o_acc, 8'h08)
    @(negedge i_mclk);
    `CHK(o_bit_rdata, 1'h1)
    bw(8'hd8, 1'h1);
    rd(8'hd8);
    `CHK(d, 8'h00)
    bw(8'hdf, 1'h1);
    `CHK(o_baud_double, 1'h1)
    i_acc_value = 8'h0f;
    pulse(i_acc_load);
    `CHK(o_acc, 8'h0f)
    i_muldiv_value = 8'h42;
    pulse(i_muldiv_load);
    rd(8'hf0);
    `CHK(d, 8'h42)
    i_psw_value = 8'hf0;
    pulse(i_psw_load);
    `CHK(o_psw, 8'hf0)
    @(negedge i_mclk);
    i_irq_req_set = 8'h01;
    @(negedge i_mclk);
    i_irq_req_set = 8'h00;
    `CHK(o_irq_request, 8'h01)
    wr(8'hc0, 8'h00);
    `CHK(o_irq_request, 8'h00)
    $display("test bits_and_hooks done");
    conclude();
  end
endmodule
`default_nettype wire
